// [core/got_trim.v]
// Purpose: Per-stream digital gain and offset trim with AXI4-Lite registers
// Assumes: Samples are 14-bit twos complement on the aclk domain; 10 MHz clock
// Notes:   Offset is subtracted first, then gain; result rounds and saturates
// How it works
// - Trim word: gain code bits 15-11, reserved bit 10, offset bits 9-0, all R/W.
// - Gain codes act only while global gain enable, config bit 12, is one.
// - Gain code N multiplies the stream by N times 0.2 dB; zero is unity.
// - Offset is subtracted only while global offset enable, config bit 8, is one.
// - Offset is signed ten-bit, one step equals one 14-bit sample step.
// - Register at index Dh trims converter 1 odd stream.
// - Register at index Eh trims converter 1 even stream.
// - Register at index Fh trims converter 2 odd stream.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "got_map.vh"
module got_trim (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [13:0] smp_data,
   input  wire [1:0]  smp_stream,
   input  wire        smp_valid,
   output wire        smp_ready,
   output wire [13:0] trim_data,
   output wire [1:0]  trim_stream,
   output wire        trim_valid,
   input  wire        trim_ready
);
   localparam [2:0] SEL_C1O  = 3'd0;
   localparam [2:0] SEL_C1E  = 3'd1;
   localparam [2:0] SEL_C2O  = 3'd2;
   localparam [2:0] SEL_CFG  = 3'd3;
   localparam [2:0] SEL_NONE = 3'd7;

   // Byte address to register select
   function [2:0] reg_sel;
      input [11:0] a;
      begin
         case (a[11:2])
            `GOT_IDX_C1_ODD:  reg_sel = SEL_C1O;
            `GOT_IDX_C1_EVEN: reg_sel = SEL_C1E;
            `GOT_IDX_C2_ODD:  reg_sel = SEL_C2O;
            `GOT_IDX_CFG:     reg_sel = SEL_CFG;
            default:          reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   // Merge the two low byte lanes of a write into a 16-bit word
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
         merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   // Gain code to linear factor, 10^(N*0.01) with 14 fraction bits
   function [15:0] gain_lut;
      input [4:0] n;
      begin
         case (n)
            5'h00: gain_lut = 16'h4000;
            5'h01: gain_lut = 16'h417e;
            5'h02: gain_lut = 16'h4304;
            5'h03: gain_lut = 16'h4494;
            5'h04: gain_lut = 16'h462d;
            5'h05: gain_lut = 16'h47cf;
            5'h06: gain_lut = 16'h497b;
            5'h07: gain_lut = 16'h4b32;
            5'h08: gain_lut = 16'h4cf2;
            5'h09: gain_lut = 16'h4ebd;
            5'h0a: gain_lut = 16'h5092;
            5'h0b: gain_lut = 16'h5273;
            5'h0c: gain_lut = 16'h545e;
            5'h0d: gain_lut = 16'h5655;
            5'h0e: gain_lut = 16'h5858;
            5'h0f: gain_lut = 16'h5a67;
            5'h10: gain_lut = 16'h5c82;
            5'h11: gain_lut = 16'h5eaa;
            5'h12: gain_lut = 16'h60de;
            5'h13: gain_lut = 16'h6320;
            5'h14: gain_lut = 16'h656f;
            5'h15: gain_lut = 16'h67cc;
            5'h16: gain_lut = 16'h6a37;
            5'h17: gain_lut = 16'h6cb0;
            5'h18: gain_lut = 16'h6f38;
            5'h19: gain_lut = 16'h71cf;
            5'h1a: gain_lut = 16'h7476;
            5'h1b: gain_lut = 16'h772c;
            5'h1c: gain_lut = 16'h79f3;
            5'h1d: gain_lut = 16'h7cca;
            5'h1e: gain_lut = 16'h7fb2;
            default: gain_lut = 16'h82ac;
         endcase
      end
   endfunction

   // Clamp a wide signed value into the 14-bit sample range
   function [13:0] sat14;
      input signed [31:0] v;
      begin
         if (v > `GOT_SMP_MAX) begin
            sat14 = 14'h1fff;
         end else if (v < `GOT_SMP_MIN) begin
            sat14 = 14'h2000;
         end else begin
            sat14 = v[13:0];
         end
      end
   endfunction

   reg  [15:0] trim_q [0:2];
   reg         gain_en_q;
   reg         ofs_en_q;
   reg         aw_have_q;
   reg  [11:0] aw_addr_q;
   reg         w_have_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   reg         rvalid_q;
   reg  [31:0] rdata_q;
   reg  [1:0]  rresp_q;
   reg         st_valid_q;
   reg  [13:0] st_data_q;
   reg  [1:0]  st_stream_q;
   reg  [4:0]  gain_sel;
   reg  [9:0]  ofs_sel;
   reg         trim_on;
   reg  [31:0] rd_word;
   wire [2:0]  wr_sel;
   wire [2:0]  rd_sel;
   wire        do_write;
   wire        fifo_in_ready;
   wire        global_gain_trim_enable;
   wire        global_offset_trim_enable;
   wire [4:0]  conv1_odd_gain_code;
   wire [9:0]  conv1_odd_offset_code;
   wire [4:0]  conv1_even_gain_code;
   wire [9:0]  conv1_even_offset_code;
   wire [4:0]  conv2_odd_gain_code;
   wire [9:0]  conv2_odd_offset_code;
   wire signed [14:0] ofs_ext;
   wire signed [14:0] diff_s;
   wire signed [16:0] coef_s;
   wire signed [31:0] prod_s;
   wire signed [31:0] scaled_s;
   integer i;

   // Field views of the trim words
   assign conv1_odd_gain_code    = trim_q[0][`GOT_GAIN_MSB:`GOT_GAIN_LSB];
   assign conv1_odd_offset_code  = trim_q[0][`GOT_OFS_MSB:`GOT_OFS_LSB];
   assign conv1_even_gain_code   = trim_q[1][`GOT_GAIN_MSB:`GOT_GAIN_LSB];
   assign conv1_even_offset_code = trim_q[1][`GOT_OFS_MSB:`GOT_OFS_LSB];
   assign conv2_odd_gain_code    = trim_q[2][`GOT_GAIN_MSB:`GOT_GAIN_LSB];
   assign conv2_odd_offset_code  = trim_q[2][`GOT_OFS_MSB:`GOT_OFS_LSB];
   assign global_gain_trim_enable   = gain_en_q;
   assign global_offset_trim_enable = ofs_en_q;

   // Write channel handshakes; address and data taken in either order
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign do_write      = aw_have_q && w_have_q && !bvalid_q;
   assign wr_sel        = reg_sel(aw_addr_q);

   // Write path and register storage
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `GOT_RESP_OKAY;
         gain_en_q <= `GOT_CFG_RESET;
         ofs_en_q  <= `GOT_CFG_RESET;
         for (i = 0; i < 3; i = i + 1) begin
            trim_q[i] <= `GOT_TRIM_RESET;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= `GOT_RESP_OKAY;
            case (wr_sel)
               SEL_C1O, SEL_C1E, SEL_C2O: begin
                  trim_q[wr_sel[1:0]] <= merge16(trim_q[wr_sel[1:0]], w_data_q, w_strb_q);
               end
               SEL_CFG: begin
                  if (w_strb_q[1]) begin
                     gain_en_q <= w_data_q[`GOT_CFG_GAIN_EN];
                     ofs_en_q  <= w_data_q[`GOT_CFG_OFS_EN];
                  end
               end
               default: begin
                  bresp_q <= `GOT_RESP_SLVERR;
               end
            endcase
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Read channel
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign rd_sel        = reg_sel(s_axi_araddr);

   // Readback word for the addressed register
   always @* begin
      rd_word = 32'h0000_0000;
      case (rd_sel)
         SEL_C1O, SEL_C1E, SEL_C2O: begin
            rd_word[15:0] = trim_q[rd_sel[1:0]];
         end
         SEL_CFG: begin
            rd_word[`GOT_CFG_GAIN_EN] = gain_en_q;
            rd_word[`GOT_CFG_OFS_EN]  = ofs_en_q;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // Read response register
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `GOT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= (rd_sel == SEL_NONE) ? `GOT_RESP_SLVERR : `GOT_RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Pick the trim codes of the incoming stream
   always @* begin
      trim_on  = 1'b1;
      gain_sel = 5'h00;
      ofs_sel  = 10'h000;
      case (smp_stream)
         `GOT_STR_C1_ODD: begin
            gain_sel = conv1_odd_gain_code;
            ofs_sel  = conv1_odd_offset_code;
         end
         `GOT_STR_C1_EVEN: begin
            gain_sel = conv1_even_gain_code;
            ofs_sel  = conv1_even_offset_code;
         end
         `GOT_STR_C2_ODD: begin
            gain_sel = conv2_odd_gain_code;
            ofs_sel  = conv2_odd_offset_code;
         end
         default: begin
            trim_on = 1'b0;
         end
      endcase
   end

   // Offset subtract, then gain with rounding; unity factor keeps the sample exact
   assign ofs_ext  = (trim_on && global_offset_trim_enable) ?
                     {{5{ofs_sel[9]}}, ofs_sel} : 15'h0000;
   assign diff_s   = $signed({smp_data[13], smp_data}) - ofs_ext;
   assign coef_s   = (trim_on && global_gain_trim_enable) ?
                     $signed({1'b0, gain_lut(gain_sel)}) :
                     $signed({1'b0, `GOT_GAIN_UNITY});
   assign prod_s   = diff_s * coef_s;
   assign scaled_s = (prod_s + `GOT_ROUND_HALF) >>> `GOT_GAIN_FRAC;

   // Result stage; stalls when the output FIFO is full
   assign smp_ready = !st_valid_q || fifo_in_ready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         st_valid_q  <= 1'b0;
         st_data_q   <= 14'h0000;
         st_stream_q <= 2'h0;
      end else if (smp_ready) begin
         st_valid_q <= smp_valid;
         if (smp_valid) begin
            st_data_q   <= sat14(scaled_s);
            st_stream_q <= smp_stream;
         end
      end
   end

   // Output buffer
   got_fifo #(
      .W     (`GOT_FIFO_W),
      .DEPTH (`GOT_FIFO_DEPTH),
      .AW    (`GOT_FIFO_AW)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   ({st_stream_q, st_data_q}),
      .in_valid  (st_valid_q),
      .in_ready  (fifo_in_ready),
      .out_data  ({trim_stream, trim_data}),
      .out_valid (trim_valid),
      .out_ready (trim_ready)
   );
endmodule // got_trim

// [include/got_map.vh]
// Purpose: Register map, field layout and datapath constants for the trim block
// Assumes: 32-bit AXI4-Lite bus, each register one aligned word at index times four
// Notes:   Register indices are kept as printed; byte address is four times the index
`ifndef GOT_MAP_VH
`define GOT_MAP_VH

// Register indices (byte address = index * 4)
`define GOT_IDX_CFG        10'h003
`define GOT_IDX_C1_ODD     10'h00d
`define GOT_IDX_C1_EVEN    10'h00e
`define GOT_IDX_C2_ODD     10'h00f

// Trim register fields
`define GOT_GAIN_MSB       15
`define GOT_GAIN_LSB       11
`define GOT_RSVD_BIT       10
`define GOT_OFS_MSB        9
`define GOT_OFS_LSB        0
`define GOT_TRIM_RESET     16'h0000

// Configuration register fields
`define GOT_CFG_GAIN_EN    12
`define GOT_CFG_OFS_EN     8
`define GOT_CFG_RESET      1'b0

// Response codes
`define GOT_RESP_OKAY      2'b00
`define GOT_RESP_SLVERR    2'b10

// Datapath
`define GOT_SMP_W          14
`define GOT_GAIN_FRAC      14
`define GOT_GAIN_UNITY     16'h4000
`define GOT_ROUND_HALF     32'sh0000_2000
`define GOT_SMP_MAX        32'sh0000_1fff
`define GOT_SMP_MIN        -32'sh0000_2000
`define GOT_FIFO_W         16
`define GOT_FIFO_DEPTH     4
`define GOT_FIFO_AW        2

// Stream codes on the sample port
`define GOT_STR_C1_ODD     2'd0
`define GOT_STR_C1_EVEN    2'd1
`define GOT_STR_C2_ODD     2'd2

`endif

// [core/got_fifo.v]
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two and equals 2**AW
// Notes:   Read data come straight from the storage flops at the read pointer
`timescale 1ns/1ps
module got_fifo #(
   parameter W     = 16,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [W-1:0]  in_data,
   input  wire          in_valid,
   output wire          in_ready,
   output wire [W-1:0]  out_data,
   output wire          out_valid,
   input  wire          out_ready
);
   localparam [AW:0] FULL = DEPTH[AW:0];

   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr_q;
   reg  [AW-1:0] rd_ptr_q;
   reg  [AW:0]   cnt_q;
   wire          push;
   wire          pop;

   // Honest full and empty from the fill count
   assign in_ready  = (cnt_q != FULL);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage, no reset needed on data
   always @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and count
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         cnt_q    <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // got_fifo

// [bench/got_trim_assertions.sv]
// Purpose: Port-level checks for the trim block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every got_trim instance
`timescale 1ns/1ps
module got_trim_chk (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [13:0] smp_data,
   input wire [1:0]  smp_stream,
   input wire        smp_valid,
   input wire        smp_ready,
   input wire [13:0] trim_data,
   input wire [1:0]  trim_stream,
   input wire        trim_valid,
   input wire        trim_ready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshake events
   wire wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire rd_go  = s_axi_arvalid && s_axi_arready;
   wire smp_go = smp_valid && smp_ready;
   property p_wr_lat; wr_go |-> ##2 s_axi_bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_aw_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw_blk: assert property (p_aw_blk) else $error("write taken while answering");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
   a_b_done: assert property (p_b_done) else $error("write answer not closed");
   property p_rd_lat; rd_go |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_blk: assert property (p_ar_blk) else $error("read taken while answering");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
   a_r_done: assert property (p_r_done) else $error("read answer not closed");
   property p_hold;
      trim_valid && !trim_ready |=> trim_valid && $stable(trim_data) && $stable(trim_stream);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed while stalled");
   property p_smp_lat; smp_go && !trim_valid |-> ##2 trim_valid; endproperty
   a_smp_lat: assert property (p_smp_lat) else $error("result late");
   property p_pass;
      smp_go && !trim_valid && !$past(smp_go) && smp_stream == 2'd3 |->
         ##2 trim_valid && trim_stream == 2'd3 && trim_data == $past(smp_data, 2);
   endproperty
   a_pass: assert property (p_pass) else $error("pass stream altered");
   c_wr: cover property (wr_go);
   c_full: cover property (smp_valid && !smp_ready);
   c_stall: cover property (trim_valid && !trim_ready);
endmodule // got_trim_chk

bind got_trim got_trim_chk u_got_trim_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .smp_data, .smp_stream, .smp_valid, .smp_ready, .trim_data,
   .trim_stream, .trim_valid, .trim_ready);

// [bench/got_trim_tb_top.sv]
// Purpose: Self-checking bench for the trim block
// Assumes: 10 MHz aclk, bench acts as AXI4-Lite master and sample source
// Notes:   Reference model in integers and a queue of expected results
`timescale 1ns/1ps
`include "got_map.vh"
module got_trim_tb_top;
   reg         aclk = 0, aresetn = 0;
   reg  [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg  [31:0] s_axi_wdata = 0;
   reg  [3:0]  s_axi_wstrb = 0;
   reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg         s_axi_arvalid = 0, s_axi_rready = 0, smp_valid = 0, trim_ready = 1;
   reg  [13:0] smp_data = 0;
   reg  [1:0]  smp_stream = 0;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp, trim_stream;
   wire [31:0] s_axi_rdata;
   wire        smp_ready, trim_valid;
   wire [13:0] trim_data;
   int         seed = 11, bad_count = 0, num_checks = 0, cyc = 0, rmode = 0, n, j, k;
   reg  [15:0] m_trim [0:2] = '{16'h0, 16'h0, 16'h0};
   reg         m_gen = 0, m_oen = 0;
   int         expq[$];

   got_trim u_got_trim (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .smp_data, .smp_stream, .smp_valid, .smp_ready, .trim_data,
      .trim_stream, .trim_valid, .trim_ready);

   always #50 aclk = ~aclk;

   // Reference result: offset first, then gain, round and saturate
   function automatic int f_trim(input [1:0] st, input [13:0] s);
      int d, g, r;
      d = $signed(s);
      g = 16384;
      if (st != 2'd3 && m_oen) d = d - $signed(m_trim[st][9:0]);
      if (st != 2'd3 && m_gen) g = $rtoi(16384.0 * 10.0 ** (m_trim[st][15:11] * 0.01) + 0.5);
      r = (d * g + 8192) >>> 14;
      if (r > 8191) r = 8191;
      if (r < -8192) r = -8192;
      return {st, r[13:0]};
   endfunction

   // Expected read answer as {resp, data}
   function automatic [33:0] f_rd(input [11:0] a);
      if (a == 12'h00c) return {`GOT_RESP_OKAY, 19'h0, m_gen, 3'h0, m_oen, 8'h0};
      if (a >= 12'h034 && a <= 12'h03c) return {`GOT_RESP_OKAY, 16'h0, m_trim[a[5:2] - 4'd13]};
      return {`GOT_RESP_SLVERR, 32'h0};
   endfunction

   task chk(input [33:0] got, input [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task summarize;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input [11:0] a, input [31:0] d, input [3:0] st);
      reg [33:0] e;
      bit fa, fw;
      e = f_rd(a);
      fa = 0;
      fw = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= st;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!(fa && fw)) begin
         @(posedge aclk);
         if (!fa && s_axi_awready) begin fa = 1; s_axi_awvalid <= 0; end
         if (!fw && s_axi_wready) begin fw = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp, e[33:32]);
      if (a == 12'h00c && st[1]) begin m_gen = d[12]; m_oen = d[8]; end
      if (e[33:32] == `GOT_RESP_OKAY && a != 12'h00c) begin
         if (st[0]) m_trim[a[5:2] - 4'd13][7:0] = d[7:0];
         if (st[1]) m_trim[a[5:2] - 4'd13][15:8] = d[15:8];
      end
   endtask

   task automatic rd(input [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk({s_axi_rresp, s_axi_rdata}, f_rd(a));
   endtask

   // Offer one sample, valid left high for back-to-back use
   task snd(input [1:0] st, input [13:0] d);
      smp_stream <= st; smp_data <= d; smp_valid <= 1;
      do @(posedge aclk); while (smp_ready !== 1'b1);
   endtask

   // Scoreboard and output back-pressure
   always @(posedge aclk) begin
      if (aresetn && smp_valid && smp_ready) expq.push_back(f_trim(smp_stream, smp_data));
      if (aresetn && trim_valid && trim_ready) begin
         chk(expq.size() != 0, 1);
         if (expq.size() != 0) chk({trim_stream, trim_data}, expq.pop_front());
      end
      trim_ready <= (rmode == 0) || (rmode == 2 && ($random(seed) & 1));
   end

   // Hang guard
   always @(posedge aclk) if (++cyc > 20000) begin bad_count++; summarize; end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      // Reset values and an unmapped place
      for (j = 0; j < 5; j++) rd(12'h00c + (j == 0 ? 0 : 36 + 4 * j));
      // Trim words read back, lanes, a refused place
      for (j = 0; j < 3; j++) wr(12'h034 + 4 * j, $random(seed) & 32'h0000fbff, 4'hf);
      wr(12'h038, 32'h0000ffff & 32'hfbff, 4'h1);
      wr(12'h00c, 32'h0000_1100, 4'h1);
      wr(12'h044, 32'h0000_1234, 4'hf);
      for (j = 0; j < 4; j++) rd(12'h00c + (j == 0 ? 0 : 36 + 4 * j));
      // Every enable setting with random trims on all streams
      for (k = 0; k < 4; k++) begin
         for (j = 0; j < 3; j++)
            wr(12'h034 + 4 * j, (k == 2 && j == 0) ? 32'hfa00 : $random(seed) & 32'hfbff, 4'hf);
         wr(12'h00c, ($random(seed) & 32'hffffeeff) | (k[1] << 12) | (k[0] << 8), 4'h2);
         rd(12'h00c);
         rmode = 2;
         snd(2'd3, $random(seed));
         snd(2'd0, 14'h1fff);
         snd(2'd1, 14'h2000);
         repeat (20) snd($random(seed), $random(seed));
         smp_valid <= 0;
         while (expq.size() != 0) @(posedge aclk);
         rmode = 0;
      end
      // Output stalled: five samples fit, then refusal, then drain
      rmode = 1;
      repeat (3) @(posedge aclk);
      smp_stream <= 2'd2; smp_data <= 14'h0abc; smp_valid <= 1;
      n = 0;
      repeat (10) begin @(posedge aclk); n += smp_ready; end
      chk(n, 5);
      smp_valid <= 0;
      rmode = 2;
      while (expq.size() != 0) @(posedge aclk);
      // Second reset in mid-run must clear trims and enables again
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      m_trim = '{16'h0, 16'h0, 16'h0};
      m_gen = 0;
      m_oen = 0;
      for (j = 0; j < 4; j++) rd(12'h00c + (j == 0 ? 0 : 36 + 4 * j));
      summarize;
   end
endmodule // got_trim_tb_top
